// [rtl/dlb_map.svh]
// register offsets, field positions, values and timing for the bridge host
`ifndef DLB_MAP_SVH
`define DLB_MAP_SVH
`define DLB_CLK_KHZ          125000
`define DLB_T_RESET_MS       10
`define DLB_T_STEP_MS        10
`define DLB_T_VIDEO_MS       5
`define DLB_T_ERRCHK_MS      1
`define DLB_I2C_QTR_NS       625
`define DLB_I2C_QTR_CYC      ((`DLB_I2C_QTR_NS * `DLB_CLK_KHZ + 999999) / 1000000)
`define DLB_DEV_ADDR_HI      6'h16
`define DLB_RA_SOFT_RST      8'h09
`define DLB_RA_CLK_CFG       8'h0a
`define DLB_RA_CLK_FACTOR    8'h0b
`define DLB_RA_PLL_EN        8'h0d
`define DLB_RA_IN_RANGE      8'h12
`define DLB_RA_FORMAT        8'h18
`define DLB_RA_LINE_LEN_LO   8'h20
`define DLB_RA_LINE_LEN_HI   8'h21
`define DLB_RA_VSIZE_LO      8'h24
`define DLB_RA_VSIZE_HI      8'h25
`define DLB_RA_HSYNC_W_LO    8'h2c
`define DLB_RA_HSYNC_W_HI    8'h2d
`define DLB_RA_VSYNC_W_LO    8'h30
`define DLB_RA_VSYNC_W_HI    8'h31
`define DLB_RA_H_BACK        8'h34
`define DLB_RA_V_BACK        8'h36
`define DLB_RA_H_FRONT       8'h38
`define DLB_RA_V_FRONT       8'h3a
`define DLB_RA_PATTERN       8'h3c
`define DLB_RA_ERR           8'he5
`define DLB_ERR_CLEAR        8'hff
`define DLB_BIT_SET          8'h01
`define DLB_LOCK_BIT         7
`define DLB_AX_CTRL          2'h0
`define DLB_AX_CMD           2'h1
`define DLB_AX_ACC           2'h2
`define DLB_AX_STAT          2'h3
`define DLB_CMD_INIT         3'h1
`define DLB_CMD_PLL          3'h2
`define DLB_CMD_ULPS_IN      3'h3
`define DLB_CMD_ULPS_OUT     3'h4
`endif

// [rtl/dlb_pkg.sv]
// types shared by the bridge host modules
package dlb_pkg;
  typedef enum logic [4:0] {
    ST_IDLE, ST_LANES, ST_RST_HIGH, ST_CONFIG, ST_PLL_ON, ST_PLL_WAIT,
    ST_SRST, ST_SRST_WAIT, ST_VIDEO, ST_ERR_CLR, ST_ERR_WAIT, ST_ERR_RD,
    ST_ERR_CHK, ST_RUN, ST_ULPS, ST_POLL, ST_POLL_CHK, ST_ULPS_SRST,
    ST_I2C_REQ, ST_I2C_WAIT, ST_TIMER
  } dlb_state_e;
  typedef struct packed {
    dlb_state_e st; dlb_state_e ret; logic [23:0] cnt;
    logic op_rd; logic [7:0] op_sub; logic [7:0] op_dat;
    logic en; logic clk_hs; logic lp11; logic video; logic ulps;
    logic retry_en; logic addr_sel; logic [2:0] wmask;
    logic err_nz; logic nack; logic refused; logic seq_ok; logic [7:0] rd_byte;
  } dlb_ctl_s;
  typedef struct packed {
    logic busy; logic rd; logic [2:0] idx; logic [3:0] bitn; logic [1:0] q;
    logic [6:0] div; logic [7:0] sh; logic scl_d; logic sda_d; logic nack;
    logic rsp; logic [7:0] rdat; logic sda_s1; logic sda_s2; logic scl_s1;
    logic scl_s2; logic [6:0] addr; logic [7:0] sub; logic [7:0] dat;
  } dlb_i2c_s;
  typedef struct packed {
    logic aw_full; logic [31:0] aw_addr; logic w_full; logic [31:0] w_data;
    logic [3:0] w_strb; logic bvalid; logic [1:0] bresp; logic rvalid;
    logic [31:0] rdata; logic [1:0] rresp;
  } dlb_axs_s;
endpackage : dlb_pkg

// [rtl/dlb_axil_slave.sv]
// axi4-lite slave front end for the four host control words
`timescale 1ns/10ps
`default_nettype none
module dlb_axil_slave (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [31:0]       awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [31:0]       araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   wr_stb,
  output logic [1:0]             wr_idx,
  output logic [31:0]            wr_data,
  input  wire logic [3:0][31:0]  rd_words
);
  import dlb_pkg::*;
  dlb_axs_s r_reg, r_next;
  logic fire, w_ok, r_ok;
  assign awready = !r_reg.aw_full;
  assign wready  = !r_reg.w_full;
  assign arready = !r_reg.rvalid;
  assign bvalid  = r_reg.bvalid;
  assign bresp   = r_reg.bresp;
  assign rvalid  = r_reg.rvalid;
  assign rdata   = r_reg.rdata;
  assign rresp   = r_reg.rresp;
  // unmapped words answer slverr and have no effect
  assign fire    = r_reg.aw_full && r_reg.w_full && !r_reg.bvalid;
  assign w_ok    = (r_reg.aw_addr[31:4] == 28'h0);
  assign r_ok    = (araddr[31:4] == 28'h0);
  assign wr_stb  = fire && w_ok && (|r_reg.w_strb);
  assign wr_idx  = r_reg.aw_addr[3:2];
  assign wr_data = r_reg.w_data;
  always_comb begin
    r_next = r_reg;
    if (r_reg.bvalid && bready) r_next.bvalid = 1'b0;
    if (r_reg.rvalid && rready) r_next.rvalid = 1'b0;
    if (awvalid && !r_reg.aw_full) begin
      r_next.aw_full = 1'b1;
      r_next.aw_addr = awaddr;
    end
    if (wvalid && !r_reg.w_full) begin
      r_next.w_full = 1'b1;
      r_next.w_data = wdata;
      r_next.w_strb = wstrb;
    end
    if (fire) begin
      r_next.aw_full = 1'b0;
      r_next.w_full  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = w_ok ? 2'h0 : 2'h2;
    end
    if (arvalid && !r_reg.rvalid) begin
      r_next.rvalid = 1'b1;
      r_next.rdata  = r_ok ? rd_words[araddr[3:2]] : 32'h0;
      r_next.rresp  = r_ok ? 2'h0 : 2'h2;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) r_reg <= '0;
    else r_reg <= r_next;
  end
endmodule : dlb_axil_slave
`default_nettype wire

// [rtl/dlb_i2c_master.sv]
// i2c master doing one register write or one register read per command
`timescale 1ns/10ps
`default_nettype none
`include "dlb_map.svh"
module dlb_i2c_master (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_read,
  input  wire logic [6:0]  dev_addr,
  input  wire logic [7:0]  cmd_sub,
  input  wire logic [7:0]  cmd_data,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_nack,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        scl_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        sda_in
);
  import dlb_pkg::*;
  localparam logic [6:0] QTR = 7'(`DLB_I2C_QTR_CYC - 1);
  dlb_i2c_s r_reg, r_next;
  // token kinds: 0 start, 1 stop, 2 write byte, 3 read byte
  function automatic logic [1:0] tok(input logic rd, input logic [2:0] i);
    if (rd) tok = (i == 3'h0 || i == 3'h4) ? 2'h0 :
                  (i == 3'h3 || i == 3'h7) ? 2'h1 : (i == 3'h6) ? 2'h3 : 2'h2;
    else tok = (i == 3'h0) ? 2'h0 : (i == 3'h4) ? 2'h1 : 2'h2;
  endfunction : tok
  function automatic logic [7:0] tbyte(input dlb_i2c_s s, input logic [2:0] i);
    tbyte = (i == 3'h1) ? {s.addr, 1'b0} : (i == 3'h2) ? s.sub :
            (i == 3'h5) ? {s.addr, 1'b1} : s.dat;
  endfunction : tbyte
  logic [1:0] kind;
  logic       tick, last;
  assign kind      = tok(r_reg.rd, r_reg.idx);
  assign last      = r_reg.idx == (r_reg.rd ? 3'h7 : 3'h4);
  // a held scl low from the target stretches the low phase before the sample
  assign tick      = (r_reg.div == 7'h0) &&
                     !(r_reg.q == 2'h2 && kind[1] && !r_reg.scl_s2);
  assign cmd_ready = !r_reg.busy;
  assign rsp_valid = r_reg.rsp;
  assign rsp_data  = r_reg.rdat;
  assign rsp_nack  = r_reg.nack;
  assign scl_out   = 1'b0;
  assign sda_out   = 1'b0;
  assign scl_oe_n  = !r_reg.scl_d;
  assign sda_oe_n  = !r_reg.sda_d;
  always_comb begin
    r_next = r_reg;
    r_next.sda_s1 = sda_in;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.scl_s1 = scl_in;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.rsp = 1'b0;
    if (!r_reg.busy) begin
      if (cmd_valid) begin
        r_next.busy = 1'b1;
        r_next.rd   = cmd_read;
        r_next.addr = dev_addr;
        r_next.sub  = cmd_sub;
        r_next.dat  = cmd_data;
        r_next.idx  = 3'h0;
        r_next.q    = 2'h0;
        r_next.bitn = 4'h0;
        r_next.nack = 1'b0;
        r_next.div  = QTR;
      end
    end else if (r_reg.div != 7'h0) begin
      r_next.div = r_reg.div - 7'h1;
    end else if (tick) begin
      r_next.div = QTR;
      r_next.q   = r_reg.q + 2'h1;
      case ({kind, r_reg.q})
        4'h0: begin r_next.scl_d = 1'b0; r_next.sda_d = 1'b0; end
        4'h1: r_next.sda_d = 1'b1;
        4'h2: r_next.scl_d = 1'b1;
        4'h4: r_next.sda_d = 1'b1;
        4'h5: r_next.scl_d = 1'b0;
        4'h6: r_next.sda_d = 1'b0;
        4'h8, 4'hc: r_next.sda_d = (r_reg.bitn != 4'h8) && !kind[0] &&
                                   !r_reg.sh[7];
        4'h9, 4'hd: r_next.scl_d = 1'b0;
        4'ha, 4'he: begin
          if (r_reg.bitn == 4'h8 && !kind[0])
            r_next.nack = r_reg.nack | r_reg.sda_s2;
          if (r_reg.bitn != 4'h8 && kind[0])
            r_next.rdat = {r_reg.rdat[6:0], r_reg.sda_s2};
        end
        default: begin
          if (kind[1]) begin
            r_next.scl_d = 1'b1;
            r_next.sh    = {r_reg.sh[6:0], 1'b0};
            r_next.bitn  = r_reg.bitn + 4'h1;
          end
        end
      endcase
      if (r_reg.q == 2'h3 && (!kind[1] || r_reg.bitn == 4'h8)) begin
        r_next.bitn = 4'h0;
        if (last) begin
          r_next.busy = 1'b0;
          r_next.rsp  = 1'b1;
        end else begin
          r_next.idx = r_reg.idx + 3'h1;
          r_next.sh  = tbyte(r_reg, r_reg.idx + 3'h1);
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) r_reg <= '0;
    else r_reg <= r_next;
  end
endmodule : dlb_i2c_master
`default_nettype wire

// [rtl/dlb_bridge_host.sv]
// host controller bringing up and running the dsi-to-lvds video bridge
// Functional notes
// - with dsi clock as source host keeps clock lane continuous high speed
// - a selected reference clock lies between 25 and 154 mhz
// - lvds and input clock ranges are written before pll use
// - pll enable is set only after source, factor and ranges written
// - host sends ulps entry on every enabled clock and data lane
// - ulps exit: exit sequence, wait lock bit, set soft reset, resume
// - reset while powered holds enable low at least 10 ms
// - during reset clock lane stays high speed, data lanes lp11; host reset leaves dsi_clk_lane_hs low until init
// - bring-up order: en low, en high, config, pll, soft reset, video
// - writing all ones to the error register clears its flags
// - error register read 1 ms after clear; nonzero repeats bring-up (host repeats only when retry_en is set, else goes to run)
// - one to four data lanes; unused lanes open or lp11
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dlb_map.svh"
module dlb_bridge_host #(
  parameter int RESET_CYC  = `DLB_T_RESET_MS * `DLB_CLK_KHZ,
  parameter int STEP_CYC   = `DLB_T_STEP_MS * `DLB_CLK_KHZ,
  parameter int VIDEO_CYC  = `DLB_T_VIDEO_MS * `DLB_CLK_KHZ,
  parameter int ERRCHK_CYC = `DLB_T_ERRCHK_MS * `DLB_CLK_KHZ
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   dev_enable,
  output logic                   dev_addr_sel,
  output logic                   dsi_clk_lane_hs,
  output logic                   dsi_data_lanes_lp11,
  output logic                   video_stream_en,
  output logic                   ulps_request,
  output logic                   scl_out,
  output logic                   scl_oe_n,
  input  wire logic              scl_in,
  output logic                   sda_out,
  output logic                   sda_oe_n,
  input  wire logic              sda_in
);
  import dlb_pkg::*;

  dlb_ctl_s          r_reg, r_next;
  logic              wr_stb;
  logic [1:0]        wr_idx;
  logic [31:0]       wr_data;
  logic [3:0][31:0]  rd_words;
  logic              i2c_ready;
  logic              i2c_rsp;
  logic [7:0]        i2c_rdata;
  logic              i2c_nack;
  logic              busy;

  // queue one i2c access, returning to ret when it completes
  function automatic dlb_ctl_s go_i2c(input dlb_ctl_s s, input logic rd,
                                      input logic [7:0] sub,
                                      input logic [7:0] dat,
                                      input dlb_state_e ret);
    go_i2c        = s;
    go_i2c.op_rd  = rd;
    go_i2c.op_sub = sub;
    go_i2c.op_dat = dat;
    go_i2c.ret    = ret;
    go_i2c.st     = ST_I2C_REQ;
  endfunction : go_i2c

  function automatic dlb_ctl_s go_wait(input dlb_ctl_s s, input int cyc,
                                       input dlb_state_e ret);
    go_wait     = s;
    go_wait.cnt = 24'(cyc - 1);
    go_wait.ret = ret;
    go_wait.st  = ST_TIMER;
  endfunction : go_wait

  // clock source, factor and range writes that must precede the pll
  function automatic logic [2:0] clk_mask(input logic [7:0] sub);
    clk_mask = {sub == `DLB_RA_IN_RANGE, sub == `DLB_RA_CLK_FACTOR,
                sub == `DLB_RA_CLK_CFG};
  endfunction : clk_mask

  dlb_axil_slave u_axil (
    .clk      (clk),
    .reset    (reset),
    .awaddr   (s_axi_awaddr),
    .awvalid  (s_axi_awvalid),
    .awready  (s_axi_awready),
    .wdata    (s_axi_wdata),
    .wstrb    (s_axi_wstrb),
    .wvalid   (s_axi_wvalid),
    .wready   (s_axi_wready),
    .bresp    (s_axi_bresp),
    .bvalid   (s_axi_bvalid),
    .bready   (s_axi_bready),
    .araddr   (s_axi_araddr),
    .arvalid  (s_axi_arvalid),
    .arready  (s_axi_arready),
    .rdata    (s_axi_rdata),
    .rresp    (s_axi_rresp),
    .rvalid   (s_axi_rvalid),
    .rready   (s_axi_rready),
    .wr_stb   (wr_stb),
    .wr_idx   (wr_idx),
    .wr_data  (wr_data),
    .rd_words (rd_words)
  );

  dlb_i2c_master u_i2c (
    .clk       (clk),
    .reset     (reset),
    .cmd_valid (r_reg.st == ST_I2C_REQ),
    .cmd_ready (i2c_ready),
    .cmd_read  (r_reg.op_rd),
    .dev_addr  ({`DLB_DEV_ADDR_HI, r_reg.addr_sel}),
    .cmd_sub   (r_reg.op_sub),
    .cmd_data  (r_reg.op_dat),
    .rsp_valid (i2c_rsp),
    .rsp_data  (i2c_rdata),
    .rsp_nack  (i2c_nack),
    .scl_out   (scl_out),
    .scl_oe_n  (scl_oe_n),
    .scl_in    (scl_in),
    .sda_out   (sda_out),
    .sda_oe_n  (sda_oe_n),
    .sda_in    (sda_in)
  );

  assign busy = !(r_reg.st == ST_IDLE || r_reg.st == ST_CONFIG ||
                  r_reg.st == ST_RUN || r_reg.st == ST_ULPS);

  assign rd_words[0] = {30'h0, r_reg.addr_sel, r_reg.retry_en};
  assign rd_words[1] = 32'h0;
  assign rd_words[2] = {15'h0, r_reg.op_rd, r_reg.op_dat, r_reg.op_sub};
  assign rd_words[3] = {11'h0, r_reg.st, r_reg.rd_byte, r_reg.wmask,
                        r_reg.refused, r_reg.nack, r_reg.err_nz,
                        r_reg.seq_ok, busy};

  assign dev_enable          = r_reg.en;
  assign dev_addr_sel        = r_reg.addr_sel;
  assign dsi_clk_lane_hs     = r_reg.clk_hs;
  assign dsi_data_lanes_lp11 = r_reg.lp11;
  assign video_stream_en     = r_reg.video;
  assign ulps_request        = r_reg.ulps;

  always_comb begin
    r_next = r_reg;
    // software orders; control word always taken, commands and accesses ignored while a sequence step is under way
    if (wr_stb) begin
      case (wr_idx)
        `DLB_AX_CTRL: begin
          r_next.retry_en = wr_data[0];
          r_next.addr_sel = wr_data[1];
        end

        `DLB_AX_CMD: begin
          case (wr_data[2:0])
            `DLB_CMD_INIT: begin
              if (r_reg.st == ST_IDLE || r_reg.st == ST_CONFIG ||
                  r_reg.st == ST_RUN) r_next.st = ST_LANES;
            end

            `DLB_CMD_PLL: begin
              if (r_reg.st == ST_CONFIG && r_reg.wmask == 3'h7)
                r_next.st = ST_PLL_ON;
              else
                r_next.refused = 1'b1;
            end

            `DLB_CMD_ULPS_IN: begin
              if (r_reg.st == ST_RUN) begin
                r_next.ulps = 1'b1;
                r_next.st   = ST_ULPS;
              end
            end

            `DLB_CMD_ULPS_OUT: begin
              if (r_reg.st == ST_ULPS) begin
                r_next.ulps = 1'b0;
                r_next.st   = ST_POLL;
              end
            end

            default: r_next.refused = 1'b1;
          endcase
        end

        `DLB_AX_ACC: begin
          // device registers stay writable in low power too
          if (r_reg.st == ST_CONFIG || r_reg.st == ST_RUN ||
              r_reg.st == ST_ULPS) begin
            r_next = go_i2c(r_next, wr_data[16], wr_data[7:0],
                            wr_data[15:8], r_reg.st);
            r_next.nack = 1'b0;
            if (!wr_data[16])
              r_next.wmask = r_reg.wmask | clk_mask(wr_data[7:0]);
          end else begin
            r_next.refused = 1'b1;
          end
        end

        default: r_next.refused = 1'b0;
      endcase
    end
    case (r_reg.st)
      ST_IDLE: ;

      ST_LANES: begin
        // lane states and enable low set in the same cycle, then held for the reset time
        r_next.clk_hs = 1'b1;
        r_next.lp11   = 1'b1;
        r_next.video  = 1'b0;
        r_next.ulps   = 1'b0;
        r_next.en     = 1'b0;
        r_next.wmask  = 3'h0;
        r_next.seq_ok = 1'b0;
        r_next.err_nz = 1'b0;
        r_next = go_wait(r_next, RESET_CYC, ST_RST_HIGH);
      end

      ST_RST_HIGH: begin
        r_next.en = 1'b1;
        r_next = go_wait(r_next, STEP_CYC, ST_CONFIG);
      end

      ST_CONFIG: ;

      ST_PLL_ON: r_next = go_i2c(r_next, 1'b0, `DLB_RA_PLL_EN,
                                 `DLB_BIT_SET, ST_PLL_WAIT);

      ST_PLL_WAIT: r_next = go_wait(r_next, STEP_CYC, ST_SRST);

      ST_SRST: r_next = go_i2c(r_next, 1'b0, `DLB_RA_SOFT_RST,
                               `DLB_BIT_SET, ST_SRST_WAIT);

      ST_SRST_WAIT: r_next = go_wait(r_next, STEP_CYC, ST_VIDEO);

      ST_VIDEO: begin
        // clock lane left in hs so the bridge can derive its pixel clock
        r_next.lp11  = 1'b0;
        r_next.video = 1'b1;
        r_next = go_wait(r_next, VIDEO_CYC, ST_ERR_CLR);
      end

      ST_ERR_CLR: r_next = go_i2c(r_next, 1'b0, `DLB_RA_ERR,
                                  `DLB_ERR_CLEAR, ST_ERR_WAIT);

      ST_ERR_WAIT: r_next = go_wait(r_next, ERRCHK_CYC, ST_ERR_RD);

      ST_ERR_RD: r_next = go_i2c(r_next, 1'b1, `DLB_RA_ERR, 8'h00,
                                 ST_ERR_CHK);

      ST_ERR_CHK: begin
        r_next.err_nz = (r_reg.rd_byte != 8'h00);
        r_next.seq_ok = (r_reg.rd_byte == 8'h00) && !r_reg.nack;
        if (r_reg.rd_byte != 8'h00 && r_reg.retry_en)
          r_next.st = ST_LANES;
        else
          r_next.st = ST_RUN;
      end

      ST_RUN: ;

      ST_ULPS: ;

      // lock polling has no limit; init is ignored while polling, only reset ends it
      ST_POLL: r_next = go_i2c(r_next, 1'b1, `DLB_RA_CLK_CFG, 8'h00,
                               ST_POLL_CHK);

      ST_POLL_CHK: begin
        if (r_reg.rd_byte[`DLB_LOCK_BIT]) begin
          r_next.st = ST_ULPS_SRST;
        end else begin
          r_next.st = ST_POLL;
        end
      end

      ST_ULPS_SRST: r_next = go_i2c(r_next, 1'b0, `DLB_RA_SOFT_RST,
                                    `DLB_BIT_SET, ST_RUN);

      // shared i2c call; ret names the step to resume when it completes
      ST_I2C_REQ: begin
        if (i2c_ready) r_next.st = ST_I2C_WAIT;
      end

      ST_I2C_WAIT: begin
        if (i2c_rsp) begin
          if (r_reg.op_rd) r_next.rd_byte = i2c_rdata;
          r_next.nack = r_reg.nack | i2c_nack;
          r_next.st   = r_reg.ret;
        end
      end

      // one shared wait counter saves a timer per step
      ST_TIMER: begin
        if (r_reg.cnt == 24'h0) begin
          r_next.st = r_reg.ret;
        end else begin
          r_next.cnt = r_reg.cnt - 24'h1;
        end
      end

      default: r_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_reg      <= '0;
      r_reg.st   <= ST_IDLE;
      r_reg.ret  <= ST_IDLE;
      r_reg.lp11 <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule : dlb_bridge_host
`default_nettype wire

// [tb/dlb_bridge_host_checker.sv]
// pin sequencing assertions for the bridge host
`timescale 1ns/10ps
`default_nettype none
module dlb_bridge_host_checker #(
  parameter int RESET_CYC = 200,
  parameter int STEP_CYC  = 200
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic dev_enable,
  input wire logic dsi_clk_lane_hs,
  input wire logic dsi_data_lanes_lp11,
  input wire logic video_stream_en,
  input wire logic ulps_request,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n
);
  int lo_q;
  int hi_q;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // counters: the waits are far too long for repetitions
  always_ff @(posedge clk) lo_q <= (reset || dev_enable) ? 0 : lo_q + 1;
  always_ff @(posedge clk) hi_q <= (reset || !dev_enable) ? 0 : hi_q + 1;
  property p_hs; $rose(dev_enable) |-> $past(dsi_clk_lane_hs); endproperty
  a_hs: assert property (p_hs) else $error("clock lane not hs");
  property p_lp; $rose(dev_enable) |-> $past(dsi_data_lanes_lp11);
  endproperty
  a_lp: assert property (p_lp) else $error("data lanes not lp11");
  property p_low; $rose(dev_enable) |-> lo_q >= RESET_CYC; endproperty
  a_low: assert property (p_low) else $error("enable low too short");
  property p_cont; video_stream_en |-> dsi_clk_lane_hs; endproperty
  a_cont: assert property (p_cont) else $error("clock lane left hs");
  property p_vl; $rose(video_stream_en) |-> !dsi_data_lanes_lp11; endproperty
  a_vl: assert property (p_vl) else $error("lanes not in hs");
  property p_vt; $rose(video_stream_en) |-> hi_q >= 3 * STEP_CYC; endproperty
  a_vt: assert property (p_vt) else $error("video too early");
  property p_off; !dev_enable |-> scl_oe_n && sda_oe_n; endproperty
  a_off: assert property (p_off) else $error("bus used while off");
  property p_ul; ulps_request |-> dev_enable; endproperty
  a_ul: assert property (p_ul) else $error("ulps without enable");
  c_en: cover property ($rose(dev_enable));
  c_video: cover property ($rose(video_stream_en));
  c_ulps: cover property ($fell(ulps_request));
endmodule : dlb_bridge_host_checker
bind dlb_bridge_host dlb_bridge_host_checker #(.RESET_CYC(RESET_CYC),
  .STEP_CYC(STEP_CYC)) u_chk (.*);
`default_nettype wire

// [tb/dlb_dev_model.sv]
// bridge device model: i2c target, registers, pll lock, error flags
`timescale 1ns/10ps
`default_nettype none
module dlb_dev_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic en,
  input  wire logic addr_pin,
  output logic      sda_oe_n
);
  logic [7:0] regs [256];
  logic [7:0] sr, so, ptr, err;
  logic       rd, hit, tx;
  int         bc, ph;
  initial sda_oe_n = 1'b1;
  always @(posedge en) err = 8'h04;
  always @(posedge scl) sr = {sr[6:0], sda};
  // start or stop: line moves while clock is high
  always @(sda) if (scl === 1'b1) begin
    {hit, rd, tx, sda_oe_n} = 4'h1;
    bc = -1;
    ph = 0;
  end
  always @(negedge scl) begin
    bc++;
    if (bc == 8 && !rd) begin
      if (ph == 0) hit = en && sr[7:1] == {6'h16, addr_pin};
      if (ph == 0) rd = sr[0];
      else if (ph == 1) ptr = sr;
      else if (ptr == 8'he5) err &= ~sr;
      else regs[ptr] = sr;
      if (ph > 1) ptr++;
      ph++;
      sda_oe_n = !hit;
    end else if (bc >= 8) begin
      sda_oe_n = 1'b1;
      if (bc == 9) begin
        bc = 0;
        tx = hit && rd && (ph == 1 || !sr[0]);
        if (tx) so = ptr == 8'he5 ? err : ptr != 8'h0a ? regs[ptr]
                     : {regs[8'h0d][0], regs[8'h0a][6:0]};
        if (tx) ptr++;
        // write phases keep counting: sub, then data
        if (rd) ph = 2;
      end
    end
    if (tx && bc < 8) sda_oe_n = so[7 - bc];
  end
endmodule : dlb_dev_model
`default_nettype wire

// [tb/tb_top.sv]
// testbench for the bridge host controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0, reset = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, q;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, m_oe_n;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, dev_enable, dev_addr_sel, dsi_clk_lane_hs;
  logic        dsi_data_lanes_lp11, video_stream_en, ulps_request;
  logic        scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  wire         scl_in = scl_oe_n;
  wire         sda_in = sda_oe_n & m_oe_n;
  int          fail_count = 0, comparisons = 0;
  always #4 clk = ~clk;
  dlb_bridge_host #(.RESET_CYC(200), .STEP_CYC(200), .VIDEO_CYC(100),
    .ERRCHK_CYC(50)) dut (.*);
  dlb_dev_model u_dev (.scl(scl_in), .sda(sda_in), .en(dev_enable),
    .addr_pin(dev_addr_sel), .sda_oe_n(m_oe_n));
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) fail_count++;
    if (g !== e) $display("[FAIL] %s expected %h seen %h", n, e, g);
  endtask : chk
  // one transfer; a spare edge first so no signal is set twice a step
  task automatic ax(input logic w, input logic [31:0] a, d);
    logic ra, rw, rr, dn;
    @(posedge clk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do begin
      @(negedge clk);
      {ra, rw, rr} = {s_axi_awready, s_axi_wready, s_axi_arready};
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      @(posedge clk);
      if (ra) s_axi_awvalid <= 1'b0;
      if (rw) s_axi_wvalid <= 1'b0;
      if (rr) s_axi_arvalid <= 1'b0;
    end while (dn !== 1'b1);
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask : ax
  task automatic cmd(input logic [31:0] a, d);
    ax(1'b1, a, d);
    do ax(1'b0, 32'hc, 32'h0); while (q[0] !== 1'b0);
  endtask : cmd
  task automatic t_refuse;
    cmd(32'h4, 32'h2);
    chk("refused", 32'h1, q[4]);
    ax(1'b1, 32'hc, 32'h0);
  endtask : t_refuse
  task automatic t_bringup;
    cmd(32'h0, 32'h2);
    cmd(32'h4, 32'h1);
    chk("pins", 32'h7, {dev_enable, dsi_clk_lane_hs, dsi_data_lanes_lp11});
    cmd(32'h8, 32'h010a);
    cmd(32'h8, 32'h200b);
    cmd(32'h4, 32'h2);
    chk("early", 32'h1, q[4]);
    ax(1'b1, 32'hc, 32'h0);
    cmd(32'h8, 32'h0012);
    cmd(32'h4, 32'h2);
    chk("status", 32'h1, q[4:1]);
    chk("video", 32'h2, {video_stream_en, dsi_data_lanes_lp11});
  endtask : t_bringup
  task automatic t_ulps;
    cmd(32'h4, 32'h3);
    chk("ulps", 32'h1, ulps_request);
    cmd(32'h4, 32'h4);
    chk("exit", 32'h81, {ulps_request, q[15:8]});
  endtask : t_ulps
  task automatic end_sim;
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_refuse();
    t_bringup();
    t_ulps();
    end_sim();
  end
  initial begin
    #800us;
    fail_count++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
